// File: spe_top.sv
// spe_top: serial front end of a byte organised spi eeprom with its arrays
// assumes cs_b, sck, si and hold_b come from pins outside the clk domain
// and that sck runs at most an eighth of the clk rate
`timescale 1ns/100ps
`default_nettype none
module spe_top #(
  parameter int WRITE_CYCLES = spe_pkg::WRITE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic cs_b,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_b,
  output var logic  so,
  output var logic  so_oe
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int PW = spe_pkg::PAGE_W;
  localparam int AW = spe_pkg::ADDR_W;

  // pin synchronisers
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic sck_m;
  logic sck_s;
  logic sck_d;
  logic si_m;
  logic si_s;
  logic hold_m;
  logic hold_s;

  // serial engine
  spe_pkg::spe_state_type state;
  spe_pkg::spe_state_type next_state;
  spe_pkg::spe_state_type op_next;
  logic [7:0]    rx;
  logic [2:0]    bit_cnt;
  logic [7:0]    opcode;
  logic          addr_hi;
  logic [AW-1:0] addr;
  logic [PW-1:0] col;
  logic [AW-PW-1:0] page_base;
  logic [spe_pkg::PAGE_BYTES-1:0] pmask;
  logic          lock_req;
  logic          wen;
  logic          locked;

  // program engine
  logic          busy;
  logic [TW-1:0] timer;
  logic          prog_lock;
  logic          prog_to_id;

  // read path
  logic [AW-1:0] rd_addr;
  logic [7:0]    tx;
  logic [2:0]    tx_cnt;

  // arrays
  logic [7:0] mem     [spe_pkg::ARRAY_BYTES];
  logic [7:0] id_mem  [spe_pkg::PAGE_BYTES];
  logic [7:0] pagebuf [spe_pkg::PAGE_BYTES];

  wire logic sel;
  wire logic active;
  wire logic rise;
  wire logic fall;
  wire logic cs_fall;
  wire logic cs_rise;
  wire logic [7:0] rx_byte;
  wire logic byte_done;
  wire logic op_take;
  wire logic op_rdsr;
  wire logic op_mem;
  wire logic is_id;
  wire logic is_wr;
  wire logic [AW-1:0] full_addr;
  wire logic addr_done;
  wire logic din_byte;
  wire logic wr_start;
  wire logic lk_start;
  wire logic start;
  wire logic prog_done;
  wire logic [PW-1:0] prog_col;
  wire logic prog_we;
  wire logic [7:0] status_val;
  wire logic rd_begin;
  wire logic pf_valid;
  wire logic pf_ready;
  wire logic [7:0] pf_data;
  wire logic ob_valid;
  wire logic ob_pop;
  wire logic [7:0] ob_data;
  wire logic [7:0] ob_byte;
  wire logic out_fall;
  wire logic next_so;
  wire logic next_oe;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_m   <= spe_pkg::CS_RST;
      cs_s   <= spe_pkg::CS_RST;
      cs_d   <= spe_pkg::CS_RST;
      sck_m  <= spe_pkg::PIN_RST;
      sck_s  <= spe_pkg::PIN_RST;
      sck_d  <= spe_pkg::PIN_RST;
      si_m   <= spe_pkg::PIN_RST;
      si_s   <= spe_pkg::PIN_RST;
      hold_m <= spe_pkg::HOLD_RST;
      hold_s <= spe_pkg::HOLD_RST;
    end else begin
      cs_m   <= cs_b;
      cs_s   <= cs_m;
      cs_d   <= cs_s;
      sck_m  <= sck;
      sck_s  <= sck_m;
      sck_d  <= sck_s;
      si_m   <= si;
      si_s   <= si_m;
      hold_m <= hold_b;
      hold_s <= hold_m;
    end
  end

  // edges found by level compare, so either idle level of sck works
  // pause masks the serial clock edges and the output enable; sck_d keeps tracking, no false edge on release
  assign sel     = ~cs_s;
  assign active  = sel & hold_s;
  assign rise    = active & sck_s & ~sck_d;
  assign fall    = active & ~sck_s & sck_d;
  assign cs_fall = ~cs_s & cs_d;
  assign cs_rise = cs_s & ~cs_d;

  assign rx_byte   = {rx[6:0], si_s};
  assign byte_done = rise & (bit_cnt == spe_pkg::LAST_BIT);

  // opcode decode; while busy only the status read gets through
  assign op_take = (state == spe_pkg::ST_OPCODE) & byte_done;
  assign op_rdsr = (rx_byte == spe_pkg::OP_RDSR);
  assign op_mem  = (rx_byte == spe_pkg::OP_READ) | (rx_byte == spe_pkg::OP_WRITE)
                 | (rx_byte == spe_pkg::OP_RDID) | (rx_byte == spe_pkg::OP_WRID);
  assign op_next = op_rdsr ? spe_pkg::ST_DOUT
                 : (op_mem & ~busy) ? spe_pkg::ST_ADDR
                 : spe_pkg::ST_IGNORE;

  assign is_id = (opcode == spe_pkg::OP_RDID) | (opcode == spe_pkg::OP_WRID);
  assign is_wr = (opcode == spe_pkg::OP_WRITE) | (opcode == spe_pkg::OP_WRID);
  assign full_addr = {addr[AW-1:8], rx_byte};
  assign addr_done = (state == spe_pkg::ST_ADDR) & byte_done & addr_hi;
  assign din_byte  = (state == spe_pkg::ST_DIN) & byte_done;

  always_comb begin
    next_state = state;
    if (!sel) begin
      next_state = spe_pkg::ST_STANDBY;
    end else if (cs_fall) begin
      next_state = spe_pkg::ST_OPCODE;
    end else begin
      unique case (state)
        spe_pkg::ST_STANDBY: next_state = state;
        spe_pkg::ST_OPCODE: begin
          if (byte_done) next_state = op_next;
        end
        spe_pkg::ST_ADDR: begin
          if (addr_done) next_state = is_wr ? spe_pkg::ST_DIN : spe_pkg::ST_DOUT;
        end
        spe_pkg::ST_DIN:    next_state = state;
        spe_pkg::ST_DOUT:   next_state = state;
        spe_pkg::ST_IGNORE: next_state = state;
        default:            next_state = spe_pkg::ST_IGNORE;
      endcase
    end
  end

  // reset holds everything in standby; select low at release still gives a select edge once synchronised
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state <= spe_pkg::ST_STANDBY;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx      <= '0;
      bit_cnt <= '0;
    end else begin
      if (rise) rx <= rx_byte;
      if (cs_fall) bit_cnt <= '0;
      else if (rise) bit_cnt <= 3'(bit_cnt + 1'b1);
    end
  end

  // opcode and two address bytes; spare high address bits are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opcode  <= '0;
      addr_hi <= 1'b0;
      addr    <= '0;
    end else begin
      if (cs_fall) addr_hi <= 1'b0;
      if (op_take) opcode <= rx_byte;
      if ((state == spe_pkg::ST_ADDR) & byte_done) begin
        addr_hi <= ~addr_hi;
        if (!addr_hi) addr[AW-1:8] <= rx_byte[AW-9:0];
        else addr <= full_addr;
      end
    end
  end

  // page gather: column wraps inside the page, mask marks bytes to program
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      col       <= '0;
      page_base <= '0;
      pmask     <= '0;
    end else if (addr_done & is_wr) begin
      col       <= full_addr[PW-1:0];
      page_base <= full_addr[AW-1:PW];
      pmask     <= '0;
    end else if (din_byte) begin
      col        <= PW'(col + 1'b1);
      pmask[col] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (din_byte) pagebuf[col] <= rx_byte;
  end

  // write enable latch, dropped again when a program cycle ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wen <= 1'b0;
    else if (prog_done) wen <= 1'b0;
    else if (op_take & ~busy & (rx_byte == spe_pkg::OP_WREN)) wen <= 1'b1;
    else if (op_take & ~busy & (rx_byte == spe_pkg::OP_WRDI)) wen <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lock_req <= 1'b0;
    else if (cs_fall) lock_req <= 1'b0;
    else if (op_take & ~busy & wen & (rx_byte == spe_pkg::OP_LOCK_ID))
      lock_req <= 1'b1;
  end

  // deselect launches the program; the front end is back in standby at once,
  // the device as a whole once busy falls
  assign wr_start = cs_rise & (state == spe_pkg::ST_DIN) & wen & (|pmask)
                  & ~(is_id & locked);
  assign lk_start = cs_rise & lock_req & ~locked;
  assign start    = wr_start | lk_start;
  assign prog_done = busy & (timer == TW'(WRITE_CYCLES - 1));
  assign prog_col  = timer[PW-1:0];
  assign prog_we   = busy & ~prog_lock & (timer < TW'(spe_pkg::PAGE_BYTES))
                   & pmask[prog_col];

  // fixed length cycle on clk alone, no serial clock needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy       <= 1'b0;
      timer      <= '0;
      prog_lock  <= 1'b0;
      prog_to_id <= 1'b0;
      locked     <= 1'b0;
    end else if (start) begin
      busy       <= 1'b1;
      timer      <= '0;
      prog_lock  <= lk_start;
      prog_to_id <= is_id;
    end else if (busy) begin
      timer <= TW'(timer + 1'b1);
      if (prog_done) begin
        busy   <= 1'b0;
        locked <= locked | prog_lock;
      end
    end
  end

  // one byte per clk during the first page-length cycles of the program
  always_ff @(posedge clk) begin
    if (prog_we & ~prog_to_id) mem[{page_base, prog_col}] <= pagebuf[prog_col];
    if (prog_we & prog_to_id) id_mem[prog_col] <= pagebuf[prog_col];
  end

  // read prefetch: the buffer lets the array run two bytes ahead of the shifter,
  // so a slow serial clock stalls the fetch instead of dropping a byte
  assign status_val = busy ? spe_pkg::STAT_BUSY
                    : (wen ? spe_pkg::STAT_WEN : spe_pkg::STAT_IDLE);
  assign rd_begin = (next_state == spe_pkg::ST_DOUT) & (state != spe_pkg::ST_DOUT);
  assign pf_valid = (state == spe_pkg::ST_DOUT) & ~rd_begin;
  assign pf_data  = (opcode == spe_pkg::OP_RDSR) ? status_val
                  : is_id ? id_mem[rd_addr[PW-1:0]] : mem[rd_addr];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rd_addr <= '0;
    else if (rd_begin) rd_addr <= full_addr;
    else if (pf_valid & pf_ready) rd_addr <= AW'(rd_addr + 1'b1);
  end

  spe_buf #(
    .WIDTH (8),
    .DEPTH (spe_pkg::OB_DEPTH)
  ) i_spe_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (rd_begin),
    .in_valid  (pf_valid),
    .in_ready  (pf_ready),
    .in_data   (pf_data),
    .out_valid (ob_valid),
    .out_ready (ob_pop),
    .out_data  (ob_data)
  );

  // output shifter: msb first, bits change on falling serial clock
  assign out_fall = fall & (state == spe_pkg::ST_DOUT);
  assign ob_pop   = out_fall & (tx_cnt == '0);
  assign ob_byte  = ob_valid ? ob_data : spe_pkg::OB_EMPTY;
  assign next_so  = (tx_cnt == '0) ? ob_byte[7] : tx[7];
  assign next_oe  = (state == spe_pkg::ST_DOUT) & active & ~cs_rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx     <= '0;
      tx_cnt <= '0;
      so     <= 1'b0;
      so_oe  <= 1'b0;
    end else begin
      so_oe <= next_oe;
      if (rd_begin) begin
        tx_cnt <= '0;
      end else if (out_fall) begin
        so     <= next_so;
        tx     <= (tx_cnt == '0) ? {ob_byte[6:0], 1'b0} : {tx[6:0], 1'b0};
        tx_cnt <= 3'(tx_cnt + 1'b1);
      end
    end
  end
endmodule : spe_top
`default_nettype wire

// File: spe_pkg.sv
// spe_pkg: sizes, opcodes, timing and state codes of the spi eeprom front end
// assumes one 20 MHz core clock that oversamples every serial pin
package spe_pkg;
  localparam int ARRAY_BYTES   = 4096;
  localparam int ADDR_W        = 12;
  localparam int PAGE_BYTES    = 32;
  localparam int PAGE_W        = 5;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_MS = 4;
  // longest time, so the division rounds down
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OB_DEPTH      = 2;

  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_RDID    = 8'h83;
  localparam logic [7:0] OP_WRID    = 8'h82;
  localparam logic [7:0] OP_LOCK_ID = 8'h8a;

  localparam logic [7:0] STAT_BUSY  = 8'hff;
  localparam logic [7:0] STAT_WEN   = 8'h02;
  localparam logic [7:0] STAT_IDLE  = 8'h00;
  localparam logic [7:0] OB_EMPTY   = 8'hff;

  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic       CS_RST     = 1'b1;
  localparam logic       HOLD_RST   = 1'b1;
  localparam logic       PIN_RST    = 1'b0;

  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_OPCODE  = 6'h02,
    ST_ADDR    = 6'h04,
    ST_DIN     = 6'h08,
    ST_DOUT    = 6'h10,
    ST_IGNORE  = 6'h20
  } spe_state_type;
endpackage : spe_pkg

// File: spe_buf.sv
// spe_buf: small first in first out buffer with valid and ready on both sides
// assumes same clock on both sides; depth of at least two
`timescale 1ns/100ps
`default_nettype none
module spe_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = spe_pkg::OB_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire logic        push;
  wire logic        pop;
  wire logic [PW-1:0] next_wr_ptr;
  wire logic [PW-1:0] next_rd_ptr;

  assign in_ready    = (count != CW'(DEPTH));
  assign out_valid   = (count != '0);
  assign out_data    = slot[rd_ptr];
  assign push        = in_valid & in_ready;
  assign pop         = out_valid & out_ready;
  assign next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
  assign next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      count <= CW'(count + CW'(push) - CW'(pop));
    end
  end

  // storage needs no reset; count says what is valid
  always_ff @(posedge clk) begin
    if (push) slot[wr_ptr] <= in_data;
  end
endmodule : spe_buf
`default_nettype wire

// File: spe_top_props.sv
// spe_top_props: concurrent checks on the serial pins of spe_top
// assumes pins change away from the clk rising edge; bound in below
`timescale 1ns/100ps
`default_nettype none
module spe_top_props #(
  parameter int WRITE_CYCLES = spe_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_b,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_d;
  logic [3:0] bit_cnt;
  logic [7:0] op;
  logic [3:0] fall_age;
  wire logic  sck_rise = sck & ~sck_d;
  wire logic  sck_fall = ~sck & sck_d;
  wire logic  op_known = op inside {spe_pkg::OP_WREN, spe_pkg::OP_WRDI, spe_pkg::OP_RDSR,
                                    spe_pkg::OP_READ, spe_pkg::OP_WRITE, spe_pkg::OP_RDID,
                                    spe_pkg::OP_WRID, spe_pkg::OP_LOCK_ID};
  // opcode rebuilt at the pins, so undefined codes can be told apart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d    <= 1'b0;
      bit_cnt  <= 4'h0;
      op       <= 8'h00;
      fall_age <= 4'hf;
    end else begin
      sck_d    <= sck;
      fall_age <= sck_fall ? 4'h0 : ((fall_age == 4'hf) ? fall_age : fall_age + 4'h1);
      if (cs_b) begin
        bit_cnt <= 4'h0;
      end else if (sck_rise && bit_cnt != 4'h8) begin
        bit_cnt <= bit_cnt + 4'h1;
        op      <= {op[6:0], si};
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RESET_QUIET: assert property ($rose(rst_b) |-> (!so_oe) [*3])
    else $error("output enabled right after reset");
  AST_DESELECT_FLOAT: assert property (cs_b [*5] |-> !so_oe)
    else $error("output driven while deselected");
  AST_HOLD_FLOAT: assert property ((!hold_b) [*5] |-> !so_oe)
    else $error("output driven during pause");
  AST_OE_NEEDS_SELECT: assert property ($rose(so_oe) |-> !$past(cs_b, 3) && $past(hold_b, 3))
    else $error("output enabled without select");
  AST_OE_AFTER_OPCODE: assert property ($rose(so_oe) |-> bit_cnt == 4'h8)
    else $error("output enabled before opcode complete");
  AST_SO_AFTER_FALL: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> fall_age >= 4'h1 && fall_age <= 4'h6)
    else $error("serial output changed away from a falling clock");
  AST_UNDEF_QUIET: assert property (bit_cnt == 4'h8 && !op_known && !cs_b |-> !so_oe)
    else $error("output driven after undefined opcode");
  AST_OE_DROP_CAUSE: assert property ($fell(so_oe) |-> $past(cs_b, 3) || !$past(hold_b, 3))
    else $error("output released without deselect or pause");
endmodule : spe_top_props
bind spe_top spe_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_spe_top_props (
  .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .si(si), .hold_b(hold_b),
  .so(so), .so_oe(so_oe));
`default_nettype wire

// File: spe_master.sv
// spe_master: behavioural spi master facing the eeprom front end
// assumes its tasks are called from the bench; pins move at falling clk
`timescale 1ns/100ps
`default_nettype none
module spe_master (
  input  wire logic clk,
  output var logic  cs_b,
  output var logic  sck,
  output var logic  si,
  output var logic  hold_b,
  input  wire logic so,
  input  wire logic so_oe
);
  logic mode3 = 1'b0;
  initial begin
    cs_b   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_b = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  // idle clock level picks mode 0 or mode 3
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck   = m3;
    wait_clk(4);
    cs_b = 1'b0;
    wait_clk(4);
  endtask : open_frame
  // bytes are sent as the bench gives them; only the refusal case sends an unknown code
  task automatic shift_byte(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si  = tx[i];
      wait_clk(4);
      if (i == hold_at) begin
        hold_b = 1'b0;
        wait_clk(20);
        hold_b = 1'b1;
        wait_clk(4);
      end
      sck = 1'b1;
      wait_clk(4);
      // a floating line reads as the inverse, so stale data cannot pass
      rx[i] = so_oe ? so : ~so;
    end
  endtask : shift_byte
  task automatic close_frame();
    if (!mode3) begin
      sck = 1'b0;
    end
    wait_clk(4);
    cs_b = 1'b1;
    // released data line must not keep looking valid
    si = ~si;
    wait_clk(8);
  endtask : close_frame
endmodule : spe_master
`default_nettype wire

// File: test_spi_eeprom_serial_front_end.sv
// test_spi_eeprom_serial_front_end: scenario bench for spe_top
// assumes spe_master drives the pins and spe_top_props is bound in
`timescale 1ns/100ps
`default_nettype none
module test_spi_eeprom_serial_front_end;
  // short program cycle keeps the run brief
  localparam int WCYC = 1000;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  wire        cs_b;
  wire        sck;
  wire        si;
  wire        hold_b;
  wire        so;
  wire        so_oe;
  int         fail_count = 0;
  int         num_checks = 0;
  logic       oe_seen;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] expq[$];
  always #25 clk = ~clk;
  always @(posedge clk) if (so_oe === 1'b1) oe_seen = 1'b1;
  spe_top #(.WRITE_CYCLES(WCYC)) i_spe_top (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
    .sck(sck), .si(si), .hold_b(hold_b), .so(so), .so_oe(so_oe));
  spe_master i_spe_master (.clk(clk), .cs_b(cs_b), .sck(sck), .si(si), .hold_b(hold_b),
    .so(so), .so_oe(so_oe));
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag
  task automatic run_frame(input logic m3, input int hold_byte);
    logic [7:0] b;
    rxq = {};
    oe_seen = 1'b0;
    i_spe_master.open_frame(m3);
    foreach (txq[k]) begin
      i_spe_master.shift_byte(txq[k], (k == hold_byte) ? 3 : -1, b);
      rxq.push_back(b);
    end
    i_spe_master.close_frame();
  endtask : run_frame
  // status streams with a lag, so the third byte is judged
  task automatic status(input logic [7:0] exp);
    txq = {spe_pkg::OP_RDSR, 8'h00, 8'h00, 8'h00};
    run_frame(1'b0, -1);
    check_byte("status", exp, rxq[3]);
  endtask : status
  task automatic send(input logic [7:0] op);
    txq = {op};
    run_frame(1'b0, -1);
  endtask : send
  task automatic read_check(input logic [7:0] op, input logic m3, input int hold,
                            input logic [7:0] hi, input logic [7:0] lo);
    txq = {op, hi, lo};
    foreach (expq[k]) txq.push_back(8'h00);
    run_frame(m3, hold);
    foreach (expq[k]) check_byte("read data", expq[k], rxq[3 + k]);
  endtask : read_check
  task automatic test_page_write();
    send(spe_pkg::OP_WREN);
    status(8'h02);
    txq = {spe_pkg::OP_WRITE, 8'h00, 8'h3e, 8'ha5, 8'h5a, 8'h3c};
    run_frame(1'b1, -1);
    status(8'hff);
    txq = {spe_pkg::OP_READ, 8'h00, 8'h3e, 8'h00};
    run_frame(1'b0, -1);
    check_flag("read while busy", 1'b0, oe_seen);
    i_spe_master.wait_clk(WCYC);
    status(8'h00);
    expq = {8'ha5, 8'h5a};
    read_check(spe_pkg::OP_READ, 1'b0, -1, 8'h00, 8'h3e);
    expq = {8'h3c};
    read_check(spe_pkg::OP_READ, 1'b1, -1, 8'hf0, 8'h20);
    $display("page write test done");
  endtask : test_page_write
  task automatic test_hold_and_undef();
    expq = {8'ha5, 8'h5a};
    read_check(spe_pkg::OP_READ, 1'b0, 3, 8'h00, 8'h3e);
    txq = {8'hff, 8'h00, 8'h3e, 8'h00};
    run_frame(1'b0, -1);
    check_flag("undefined opcode output", 1'b0, oe_seen);
    expq = {8'ha5};
    read_check(spe_pkg::OP_READ, 1'b1, -1, 8'h00, 8'h3e);
    // write disable must drop the latch, so the next write programs nothing
    send(spe_pkg::OP_WREN);
    send(spe_pkg::OP_WRDI);
    txq = {spe_pkg::OP_WRITE, 8'h00, 8'h3e, 8'h11};
    run_frame(1'b0, -1);
    status(8'h00);
    expq = {8'ha5};
    read_check(spe_pkg::OP_READ, 1'b0, -1, 8'h00, 8'h3e);
    $display("hold and undefined test done");
  endtask : test_hold_and_undef
  task automatic test_id_page();
    send(spe_pkg::OP_WREN);
    txq = {spe_pkg::OP_WRID, 8'h00, 8'h05, 8'h77};
    run_frame(1'b0, -1);
    i_spe_master.wait_clk(WCYC);
    expq = {8'h77};
    read_check(spe_pkg::OP_RDID, 1'b0, -1, 8'h00, 8'h05);
    send(spe_pkg::OP_WREN);
    send(spe_pkg::OP_LOCK_ID);
    i_spe_master.wait_clk(WCYC);
    send(spe_pkg::OP_WREN);
    txq = {spe_pkg::OP_WRID, 8'h00, 8'h05, 8'h88};
    run_frame(1'b0, -1);
    i_spe_master.wait_clk(WCYC);
    read_check(spe_pkg::OP_RDID, 1'b1, -1, 8'h00, 8'h05);
    $display("id page test done");
  endtask : test_id_page
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    i_spe_master.wait_clk(4);
    test_page_write();
    test_hold_and_undef();
    test_id_page();
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : test_spi_eeprom_serial_front_end
`default_nettype wire
